// ===== logic/swr_pkg.sv
package swr_pkg;
  // ****************************************
  // clock and time base
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DW = 16;
  localparam int TW = 25;

  // ****************************************
  // supervisory times, figures as specified
  // ****************************************
  localparam real HOLD_0_MS = 1.4;
  localparam real HOLD_1_MS = 28.0;
  localparam real HOLD_2_MS = 200.0;
  localparam real HOLD_3_MS = 1600.0;
  localparam real WD_0_MS = 6.3;
  localparam real WD_1_MS = 102.0;
  localparam real WD_2_MS = 1600.0;
  localparam real WD_3_S = 25.6;
  localparam real MR_OFF_S = 4.0;
  localparam real MR_ON_MS = 500.0;
  localparam real RESET_DELAY_US = 20.0;
  localparam int GLITCH_NS = 100;
  localparam int KICK_MIN_NS = 80;

  // ****************************************
  // derived counts (ticks of 1 us, cycles of pclk)
  // ****************************************
  localparam real TICKS_PER_MS = 1.0e6 / TICK_NS;
  localparam logic [TW-1:0] HOLD_0_T = TW'(int'(HOLD_0_MS * TICKS_PER_MS));
  localparam logic [TW-1:0] HOLD_1_T = TW'(int'(HOLD_1_MS * TICKS_PER_MS));
  localparam logic [TW-1:0] HOLD_2_T = TW'(int'(HOLD_2_MS * TICKS_PER_MS));
  localparam logic [TW-1:0] HOLD_3_T = TW'(int'(HOLD_3_MS * TICKS_PER_MS));
  localparam logic [TW-1:0] WD_0_T = TW'(int'(WD_0_MS * TICKS_PER_MS));
  localparam logic [TW-1:0] WD_1_T = TW'(int'(WD_1_MS * TICKS_PER_MS));
  localparam logic [TW-1:0] WD_2_T = TW'(int'(WD_2_MS * TICKS_PER_MS));
  localparam logic [TW-1:0] WD_3_T = TW'(int'(WD_3_S * 1000.0 * TICKS_PER_MS));
  localparam logic [TW-1:0] MR_OFF_T = TW'(int'(MR_OFF_S * 1000.0 * TICKS_PER_MS));
  localparam logic [TW-1:0] MR_ON_T = TW'(int'(MR_ON_MS * TICKS_PER_MS));
  localparam logic [TW-1:0] RD_T = TW'(int'(RESET_DELAY_US * TICKS_PER_MS / 1000.0));
  localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MR_FILT = GLITCH_CYCLES + 1;
  localparam int KICK_FILT = KICK_MIN_NS / CLK_PERIOD_NS / 2;

  // ****************************************
  // register map
  // ****************************************
  localparam int AW = 12;
  localparam logic [AW-1:0] CTRL_OFF = 12'h000;
  localparam logic [AW-1:0] STAT_OFF = 12'h004;
  localparam int CTRL_HOLD_LSB = 0;
  localparam int CTRL_WD_LSB = 2;
  localparam int CTRL_MODE_BIT = 4;
  localparam logic [1:0] HOLD_SEL_RST = 2'h2;
  localparam logic [1:0] WD_SEL_RST = 2'h2;
  localparam logic MR_MODE_RST = 1'b0;
  localparam int ST_RST_BIT = 0;
  localparam int ST_DOWN_BIT = 1;
  localparam int ST_FLOAT_BIT = 2;
  localparam int ST_RUN_LSB = 4;
  localparam int ST_STATE_LSB = 8;
  localparam int ST_WDX_BIT = 16;

  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_ASSERT = 5'h02,
    ST_HOLD = 5'h04,
    ST_RUN = 5'h08,
    ST_DOWN = 5'h10
  } swr_state_t;

  function automatic logic [TW-1:0] hold_ticks(input logic [1:0] sel);
    hold_ticks = (sel == 2'h0) ? HOLD_0_T : (sel == 2'h1) ? HOLD_1_T :
                 (sel == 2'h2) ? HOLD_2_T : HOLD_3_T;
  endfunction : hold_ticks

  function automatic logic [TW-1:0] wd_ticks(input logic [1:0] sel);
    wd_ticks = (sel == 2'h0) ? WD_0_T : (sel == 2'h1) ? WD_1_T :
               (sel == 2'h2) ? WD_2_T : WD_3_T;
  endfunction : wd_ticks
endpackage : swr_pkg

// ===== logic/swr_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface swr_cfg_if;
  logic [1:0] hold_sel;
  logic [1:0] wd_sel;
  logic mr_mode;
  logic cfg_restore;
  logic wd_fire;
  logic [31:0] status;
  modport regs (output hold_sel, output wd_sel, output mr_mode,
                input cfg_restore, input wd_fire, input status);
  modport core (input hold_sel, input wd_sel, input mr_mode,
                output cfg_restore, output wd_fire, output status);
endinterface : swr_cfg_if
`default_nettype wire

// ===== logic/swr_deglitch.sv
`timescale 1ns/1ps
`default_nettype none
module swr_deglitch #(
  parameter int FILT = 4,
  parameter logic INIT = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  // ****************************************
  // two-stage sync, then a change must stand FILT samples
  // ****************************************
  logic s1_q;
  logic s2_q;
  logic out_q;
  logic [7:0] cnt_q;
  wire logic same = (s2_q == out_q);
  wire logic done = (cnt_q == 8'(FILT - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= INIT;
      s2_q <= INIT;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= INIT;
      cnt_q <= 8'h00;
    end else if (same) begin
      cnt_q <= 8'h00;
    end else if (done) begin
      out_q <= s2_q;
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign dout = out_q;
endmodule : swr_deglitch
`default_nettype wire

// ===== logic/swr_apb.sv
`timescale 1ns/1ps
`default_nettype none
module swr_apb (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [swr_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  swr_cfg_if.regs cfg
);
  import swr_pkg::*;

  // ****************************************
  // decode
  // ****************************************
  logic wdx_q;
  wire logic setup = psel & ~penable;
  wire logic access_wr = psel & penable & pwrite;
  wire logic hit_ctrl = (paddr == CTRL_OFF);
  wire logic hit_stat = (paddr == STAT_OFF);
  wire logic wr_ctrl = access_wr & hit_ctrl;
  wire logic clr_wdx = access_wr & hit_stat & pwdata[ST_WDX_BIT];
  wire logic [31:0] ctrl_rd = {27'h0, cfg.mr_mode, cfg.wd_sel, cfg.hold_sel};
  wire logic [31:0] stat_rd = cfg.status | (32'(wdx_q) << ST_WDX_BIT);
  wire logic [31:0] rd_mux = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd : 32'h0;

  // ****************************************
  // bus answer: zero wait, read data captured in setup
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        prdata <= rd_mux;
        pslverr <= ~(hit_ctrl | hit_stat);
      end
    end
  end

  // ****************************************
  // registers; shutdown restore beats a write
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg.hold_sel <= HOLD_SEL_RST;
      cfg.wd_sel <= WD_SEL_RST;
      cfg.mr_mode <= MR_MODE_RST;
    end else if (cfg.cfg_restore) begin
      cfg.hold_sel <= HOLD_SEL_RST;
      cfg.wd_sel <= WD_SEL_RST;
    end else if (wr_ctrl) begin
      cfg.hold_sel <= pwdata[CTRL_HOLD_LSB +: 2];
      cfg.wd_sel <= pwdata[CTRL_WD_LSB +: 2];
      cfg.mr_mode <= pwdata[CTRL_MODE_BIT];
    end
  end

  // expiry set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdx_q <= 1'b0;
    end else begin
      wdx_q <= cfg.wd_fire | (wdx_q & ~clr_wdx);
    end
  end
endmodule : swr_apb
`default_nettype wire

// ===== logic/swr_top.sv
// Contract
// - reset output driven low while the monitored rail is below threshold.
// - after rail recovery or watchdog expiry, reset held for full hold time.
// - hold time selectable 1.4, 28, 200 or 1600 ms; 200 ms default.
// - every kick edge, either direction, clears the watchdog; 80 ns pulses seen.
// - watchdog running a full period uncleared asserts reset.
// - watchdog period selectable 6.3, 102, 1600 ms or 25.6 s; 1600 ms default.
// - undervoltage reset on the second rail also clears the watchdog.
// - watchdog held cleared while reset asserted; counts only after release.
// - floating or undriven kick input disables the watchdog.
// - manual input works as processor reset or power switch; reset default.
// - negative glitches on manual input up to 100 ns are ignored.
// - processor mode: reset asserted while manual input held low.
// - processor mode: after manual release, reset held for hold time.
// - switch mode: manual low over 4 s shuts channels, restores hold and watchdog selects to default.
// - in shutdown, manual low 500 ms restarts channels per their enables.
// - input undervoltage asserts reset after the reset delay and keeps it.
// - supervision active only while some channel enable is high.
`timescale 1ns/1ps
`default_nettype none
module swr_top #(
  parameter int TICK_DIV = swr_pkg::TICK_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [swr_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rail_sense_in,
  input wire logic input_uv_in,
  input wire logic watchdog_kick_in,
  input wire logic kick_float_in,
  input wire logic manual_reset_n,
  input wire logic [3:0] channel_enable,
  output logic reset_out_n,
  output logic reset_out_oe,
  output logic [3:0] channel_run
);
  import swr_pkg::*;

  swr_cfg_if cfg ();

  // ****************************************
  // register slave
  // ****************************************
  swr_apb u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cfg(cfg.regs)
  );

  // ****************************************
  // pin conditioning
  // ****************************************
  logic mr_n_f;
  logic kick_f;
  logic kick_q;

  swr_deglitch #(.FILT(MR_FILT), .INIT(1'b1)) u_mr_flt (
    .clk(pclk),
    .rst_n(presetn),
    .din(manual_reset_n),
    .dout(mr_n_f)
  );

  // short filter: well below the narrowest kick pulse
  swr_deglitch #(.FILT(KICK_FILT), .INIT(1'b0)) u_kick_flt (
    .clk(pclk),
    .rst_n(presetn),
    .din(watchdog_kick_in),
    .dout(kick_f)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick_q <= 1'b0;
    end else begin
      kick_q <= kick_f;
    end
  end

  wire logic kick_edge = kick_f ^ kick_q;

  // ****************************************
  // time base
  // ****************************************
  logic [DW-1:0] div_q;
  logic tick_q;
  wire logic div_end = (div_q == DW'(TICK_DIV - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_end ? '0 : div_q + DW'(1);
      tick_q <= div_end;
    end
  end

  // ****************************************
  // state and conditions
  // ****************************************
  swr_state_t st_q;
  swr_state_t st_d;
  logic [TW-1:0] hold_cnt_q;
  logic [TW-1:0] wd_cnt_q;
  logic [TW-1:0] mr_cnt_q;
  logic [TW-1:0] uv_cnt_q;
  logic down_arm_q;

  wire logic active = |channel_enable;
  wire logic switch_mode = cfg.mr_mode;
  wire logic mr_low = ~mr_n_f;
  wire logic uv_done = (uv_cnt_q == RD_T);
  wire logic rail_low = ~rail_sense_in;
  wire logic man_rst = ~switch_mode & mr_low;
  wire logic cause = rail_low | uv_done | man_rst;
  wire logic [TW-1:0] hold_len = hold_ticks(cfg.hold_sel);
  wire logic [TW-1:0] wd_len = wd_ticks(cfg.wd_sel);
  wire logic hold_done = tick_q & (hold_cnt_q == hold_len - TW'(1));
  wire logic wd_off = kick_float_in;
  wire logic wd_clr = (st_q != ST_RUN) | kick_edge | wd_off;
  wire logic wd_expire = ~wd_clr & tick_q & (wd_cnt_q == wd_len - TW'(1));
  wire logic shut_req = switch_mode & mr_low & (mr_cnt_q == MR_OFF_T);
  wire logic restart = down_arm_q & mr_low & (mr_cnt_q == MR_ON_T);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        st_d = ST_ASSERT;
      end
      ST_ASSERT: begin
        if (!cause) st_d = ST_HOLD;
      end
      ST_HOLD: begin
        if (cause) st_d = ST_ASSERT;
        else if (hold_done) st_d = ST_RUN;
      end
      ST_RUN: begin
        if (cause) st_d = ST_ASSERT;
        else if (wd_expire) st_d = ST_HOLD;
      end
      ST_DOWN: begin
        if (restart) st_d = ST_ASSERT;
      end
      default: begin
        st_d = ST_OFF;
      end
    endcase
    // all enables low: supervision idle and shutdown cleared
    if (!active) st_d = ST_OFF;
    else if (shut_req && st_q != ST_DOWN) st_d = ST_DOWN;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // counters
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= '0;
    end else if (st_q != ST_HOLD) begin
      hold_cnt_q <= '0;
    end else if (tick_q) begin
      hold_cnt_q <= hold_cnt_q + TW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_cnt_q <= '0;
    end else if (wd_clr) begin
      wd_cnt_q <= '0;
    end else if (tick_q) begin
      wd_cnt_q <= wd_expire ? '0 : wd_cnt_q + TW'(1);
    end
  end

  // counts the press length; saturates so a long press fires once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mr_cnt_q <= '0;
    end else if (!mr_low || !switch_mode || st_d != st_q) begin
      mr_cnt_q <= '0;
    end else if (tick_q && mr_cnt_q != MR_OFF_T) begin
      mr_cnt_q <= mr_cnt_q + TW'(1);
    end
  end

  // after shutdown the button must be released before a restart press counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_arm_q <= 1'b0;
    end else if (st_q != ST_DOWN) begin
      down_arm_q <= 1'b0;
    end else if (!mr_low) begin
      down_arm_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_cnt_q <= '0;
    end else if (!input_uv_in) begin
      uv_cnt_q <= '0;
    end else if (tick_q && !uv_done) begin
      uv_cnt_q <= uv_cnt_q + TW'(1);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_out_n <= 1'b0;
      reset_out_oe <= 1'b1;
      channel_run <= 4'h0;
    end else begin
      reset_out_n <= 1'b0;
      reset_out_oe <= (st_d != ST_RUN);
      channel_run <= (st_d == ST_DOWN) ? 4'h0 : channel_enable;
    end
  end

  assign cfg.cfg_restore = (st_d == ST_DOWN) & (st_q != ST_DOWN);
  assign cfg.wd_fire = wd_expire;
  assign cfg.status = (32'(reset_out_oe) << ST_RST_BIT)
                    | (32'(st_q == ST_DOWN) << ST_DOWN_BIT)
                    | (32'(wd_off) << ST_FLOAT_BIT)
                    | (32'(channel_run) << ST_RUN_LSB)
                    | (32'(st_q) << ST_STATE_LSB);
endmodule : swr_top
`default_nettype wire

// ===== tb/swr_props.sv
`timescale 1ns/1ps
`default_nettype none
module swr_props #(
  parameter int TICK_DIV = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rail_sense_in,
  input wire logic input_uv_in,
  input wire logic watchdog_kick_in,
  input wire logic kick_float_in,
  input wire logic manual_reset_n,
  input wire logic [3:0] channel_enable,
  input wire logic reset_out_n,
  input wire logic reset_out_oe
);
  // ****************************************
  // helper counters
  // ****************************************
  // raw pin edges are seen before the design's synchroniser, so bounds stay safe
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire cause = !rail_sense_in || input_uv_in || !manual_reset_n || (channel_enable == 4'h0);
  logic kick_q;
  int quiet_q, calm_q, wd_q, uv_q, mr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kick_q <= 1'b0;
      quiet_q <= 0;
      calm_q <= 0;
      wd_q <= 0;
      uv_q <= 0;
      mr_q <= 0;
    end else begin
      kick_q <= watchdog_kick_in;
      quiet_q <= (cause || $rose(reset_out_oe)) ? 0 : quiet_q + 1;
      calm_q <= cause ? 0 : calm_q + 1;
      wd_q <= (cause || reset_out_oe || kick_float_in || watchdog_kick_in != kick_q) ? 0 : wd_q + 1;
      uv_q <= input_uv_in ? uv_q + 1 : 0;
      mr_q <= manual_reset_n ? 0 : mr_q + 1;
    end
  end
  a_rail_low_reset: assert property ((!rail_sense_in && channel_enable != 4'h0) |-> ##[1:3] reset_out_oe)
    else $error("rail low without reset");
  a_open_drain_low: assert property (reset_out_oe |-> !reset_out_n)
    else $error("reset pin driven high");
  a_uv_reset_kept: assert property ((uv_q > 20 * TICK_DIV + 4) |-> reset_out_oe)
    else $error("undervoltage without reset");
  a_manual_low_reset: assert property ((mr_q > 16) |-> reset_out_oe)
    else $error("manual low without reset");
  a_hold_full_time: assert property ($fell(reset_out_oe) |-> quiet_q >= 1399 * TICK_DIV)
    else $error("reset released early");
  a_wd_not_early: assert property (($rose(reset_out_oe) && calm_q > 30) |-> wd_q >= 6299 * TICK_DIV)
    else $error("watchdog fired early");
  a_float_no_wd: assert property (($rose(reset_out_oe) && calm_q > 30) |-> !kick_float_in)
    else $error("watchdog fired while disabled");
  a_idle_reset_held: assert property ((channel_enable == 4'h0) [*3] |-> reset_out_oe)
    else $error("idle supervisor released reset");
  c_wd_fire: cover property ($rose(reset_out_oe) && calm_q > 30);
  c_uv_reset: cover property (uv_q > 30 && reset_out_oe);
  c_release: cover property ($fell(reset_out_oe));
endmodule : swr_props
bind swr_top swr_props #(.TICK_DIV(TICK_DIV)) u_props (.pclk(pclk), .presetn(presetn),
  .rail_sense_in(rail_sense_in), .input_uv_in(input_uv_in), .watchdog_kick_in(watchdog_kick_in),
  .kick_float_in(kick_float_in), .manual_reset_n(manual_reset_n),
  .channel_enable(channel_enable), .reset_out_n(reset_out_n), .reset_out_oe(reset_out_oe));
`default_nettype wire

// ===== tb/swr_proc_model.sv
`timescale 1ns/1ps
`default_nettype none
module swr_proc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic kick_en,
  input wire logic float_en,
  input wire logic [15:0] kick_gap,
  output logic kick,
  output logic kick_float
);
  // ****************************************
  // processor kick driver
  // ****************************************
  // 8-cycle pulses are the narrowest kick the pin must honour
  logic [15:0] cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0;
      kick <= 1'b0;
    end else if (float_en) begin
      kick <= ~kick; // undriven pin wanders
    end else if (kick_en) begin
      cnt_q <= (cnt_q >= kick_gap) ? 16'h0 : cnt_q + 16'h1; // gap below period
      kick <= (cnt_q < 16'h8);
    end
  end
  assign kick_float = float_en;
endmodule : swr_proc_model
`default_nettype wire

// ===== tb/supervisor_watchdog_reset_test.sv
`timescale 1ns/1ps
`default_nettype none
module supervisor_watchdog_reset_test;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, reset_out_n, reset_out_oe, kick, kick_float;
  logic [3:0] channel_run;
  logic rail = 1'b1;
  logic uv = 1'b0;
  logic manual_n = 1'b1;
  logic [3:0] ch_en = 4'hf;
  logic kick_en = 1'b0;
  logic float_en = 1'b0;
  logic [15:0] kick_gap = 16'd100;
  logic [31:0] rnd = 32'h8cd0;
  logic [31:0] rd;
  logic er, seen;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  always #5 pclk = ~pclk;
  swr_top #(.TICK_DIV(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rail_sense_in(rail), .input_uv_in(uv), .watchdog_kick_in(kick),
    .kick_float_in(kick_float), .manual_reset_n(manual_n), .channel_enable(ch_en),
    .reset_out_n(reset_out_n), .reset_out_oe(reset_out_oe), .channel_run(channel_run));
  swr_proc_model u_proc (.pclk(pclk), .presetn(presetn), .kick_en(kick_en), .float_en(float_en),
    .kick_gap(kick_gap), .kick(kick), .kick_float(kick_float));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [31:0] ctrl_exp(input logic [31:0] d);
    ctrl_exp = {27'h0, d[4:0]};
  endfunction : ctrl_exp
  task stop_test;
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  task check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task rng(input int v, input int lo, input int hi);
    check({31'h0, (v >= lo && v <= hi)}, 32'h1);
  endtask : rng
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_oe(input logic v);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (reset_out_oe !== v);
  endtask : wait_oe
  task watch(input int cycles);
    seen = 1'b0;
    repeat (cycles) begin
      @(negedge pclk);
      seen = seen | reset_out_oe;
    end
  endtask : watch
  // limit well above the roughly 50k cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 70000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000000a);
    apb(1'b0, 12'h010, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr_next(rnd);
      apb(1'b1, 12'h000, {rnd[31:5], 5'(i)});
      apb(1'b0, 12'h000, 32'h0);
      check(rd, ctrl_exp({rnd[31:5], 5'(i)}));
    end
    apb(1'b1, 12'h000, 32'h0);
    @(posedge pclk) ch_en <= 4'h0;
    watch(5);
    check({31'h0, reset_out_oe}, 32'h1);
    check({28'h0, channel_run}, 32'h0);
    check({31'h0, reset_out_n}, 32'h0);
    @(posedge pclk) ch_en <= rnd[3:0] | 4'h1;
    wait_oe(1'b0);
    rng(n, 1399, 1420);
    check({28'h0, channel_run}, {28'h0, rnd[3:0] | 4'h1});
    wait_oe(1'b1);
    rng(n, 6299, 6310);
    wait_oe(1'b0);
    rng(n, 1399, 1410);
    apb(1'b0, 12'h004, 32'h0);
    check({31'h0, rd[16]}, 32'h1);
    apb(1'b1, 12'h004, 32'h00010000);
    apb(1'b0, 12'h004, 32'h0);
    check({31'h0, rd[16]}, 32'h0);
    kick_en <= 1'b1;
    repeat (4) begin
      rnd = lfsr_next(rnd);
      kick_gap <= 16'd20 + 16'(rnd % 5000);
      watch(5000);
      check({31'h0, seen}, 32'h0);
    end
    kick_en <= 1'b0;
    float_en <= 1'b1;
    watch(8000);
    check({31'h0, seen}, 32'h0);
    @(posedge pclk) float_en <= 1'b0;
    rail <= 1'b0;
    watch(3);
    check({31'h0, reset_out_oe}, 32'h1);
    @(posedge pclk) rail <= 1'b1;
    wait_oe(1'b0);
    rng(n, 1399, 1410);
    wait_oe(1'b1);
    rng(n, 6299, 6310);
    wait_oe(1'b0);
    kick_en <= 1'b1;
    kick_gap <= 16'd100;
    @(posedge pclk) manual_n <= 1'b0;
    repeat (10) @(posedge pclk);
    manual_n <= 1'b1;
    watch(40);
    check({31'h0, seen}, 32'h0);
    @(posedge pclk) manual_n <= 1'b0;
    repeat (100) @(posedge pclk);
    check({31'h0, reset_out_oe}, 32'h1);
    manual_n <= 1'b1;
    wait_oe(1'b0);
    rng(n, 1399, 1425);
    @(posedge pclk) uv <= 1'b1;
    watch(15);
    check({31'h0, reset_out_oe}, 32'h0);
    watch(12);
    check({31'h0, reset_out_oe}, 32'h1);
    repeat (50) @(posedge pclk);
    uv <= 1'b0;
    wait_oe(1'b0);
    rng(n, 1399, 1410);
    stop_test;
  end
endmodule : supervisor_watchdog_reset_test
`default_nettype wire
